// ### lta_consts.vh
// Constants for the light threshold alert logic: register map, field
// positions, reset values and pulse timing.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef LTA_CONSTS_VH
`define LTA_CONSTS_VH

// Register byte offsets
`define LTA_OFS_THR_LOW 8'h00
`define LTA_OFS_THR_HIGH 8'h04
`define LTA_OFS_CONFIG 8'h08
`define LTA_OFS_FLAGS 8'h0C

// Widths
`define LTA_MEAS_W 28
`define LTA_ADDR_W 8

// Config field positions
`define LTA_CFG_LATCH 0
`define LTA_CFG_POL 1
`define LTA_CFG_PERS_LO 2
`define LTA_CFG_PERS_HI 3
`define LTA_CFG_FUNC_LO 4
`define LTA_CFG_FUNC_HI 5
`define LTA_CFG_DIR 6

// Flags field positions
`define LTA_FLG_HIGH 0
`define LTA_FLG_LOW 1
`define LTA_FLG_PIN 2

// Alert function codes
`define LTA_FUNC_FAULT 2'h0
`define LTA_FUNC_FIFO 2'h3

// Reset values
`define LTA_RST_THR_LOW 28'h0000000
`define LTA_RST_THR_HIGH 28'hFFFFFFF
`define LTA_RST_CONFIG 7'h00

// Timing
`define LTA_CLK_NS 100
`define LTA_PULSE_NS 1000
`define LTA_PULSE_CYC ((`LTA_PULSE_NS + `LTA_CLK_NS - 1) / `LTA_CLK_NS)
`define LTA_HIST_LAST 2'h3

`endif

// ### lta_fault_filter.v
// Fault comparison and persistence filter for each finished measurement.
// Assumes meas_valid_i is a one-cycle pulse on core_clk_i.
`timescale 1ns/10ps
`include "lta_consts.vh"

module lta_fault_filter (
  input wire core_clk_i,
  input wire rst_i,
  input wire meas_valid_i,
  input wire [`LTA_MEAS_W-1:0] meas_value_i,
  input wire [`LTA_MEAS_W-1:0] thr_low_i,
  input wire [`LTA_MEAS_W-1:0] thr_high_i,
  input wire [1:0] persist_i,
  output reg hit_high_o,
  output reg hit_low_o,
  output reg conv_done_o
);

  // Consecutive faults needed per persistence setting
  function [3:0] lta_needed;
    input [1:0] pers;
    begin
      lta_needed = 4'h1 << pers;
    end
  endfunction

  reg [3:0] run_cnt;
  wire above;
  wire below;
  wire fault;
  wire [3:0] next_run;

  assign above = meas_value_i > thr_high_i;
  assign below = meas_value_i < thr_low_i;
  assign fault = above | below;
  assign next_run = (run_cnt == 4'hF) ? run_cnt : run_cnt + 4'h1;

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      run_cnt <= 4'h0;
      hit_high_o <= 1'b0;
      hit_low_o <= 1'b0;
      conv_done_o <= 1'b0;
    end
    else
    begin
      conv_done_o <= meas_valid_i;
      hit_high_o <= 1'b0;
      hit_low_o <= 1'b0;
      if (meas_valid_i)
      begin
        if (!fault)
        begin
          run_cnt <= 4'h0;
        end
        else
        begin
          run_cnt <= next_run;
          if (next_run >= lta_needed(persist_i))
          begin
            hit_high_o <= above;
            hit_low_o <= below;
          end
        end
      end
    end
  end

endmodule // lta_fault_filter

// ### lta_top.v
// Alert reporting logic of an ambient light sensor: limit compare,
// persistence, limit flags and open-drain alert pin, with Avalon-MM registers.
// Assumes measurements arrive on core_clk_i; the alert pin has a pull-up.
`timescale 1ns/10ps
`include "lta_consts.vh"

module lta_top (
  input wire core_clk_i,
  input wire rst_i,
  input wire [`LTA_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire meas_valid_i,
  input wire [`LTA_MEAS_W-1:0] meas_value_i,
  input wire alert_pin_i,
  output reg alert_pin_o,
  output reg alert_pin_oe_o
);

  localparam integer PULSE_CYC = `LTA_PULSE_CYC;

  // Byte-lane merge of a write into a register word
  function [31:0] lta_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer i;
    begin
      lta_merge = old_val;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (be[i])
        begin
          lta_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Pin pulls low when asserted level is low, or idle level is low
  function lta_pull_low;
    input active;
    input polarity;
    begin
      lta_pull_low = active ^ polarity;
    end
  endfunction

  reg [`LTA_MEAS_W-1:0] thr_low;
  reg [`LTA_MEAS_W-1:0] thr_high;
  reg latch_mode;
  reg alert_polarity;
  reg [1:0] persist;
  reg [1:0] alert_func;
  reg alert_dir;
  reg flag_high;
  reg flag_low;
  reg fault_state;
  reg [4:0] pulse_cnt;
  reg [1:0] hist_cnt;
  reg pin_meta;
  reg pin_sync;
  reg [31:0] rd_word;
  reg next_flag_high;
  reg next_flag_low;
  reg next_fault_state;
  reg next_pull;
  reg pulse_start;
  reg pin_active;
  reg [31:0] wr_word;

  wire hit_high;
  wire hit_low;
  wire conv_done;
  wire bus_req;
  wire bus_take;
  wire wr_done;
  wire flags_rd;
  wire [6:0] cfg_word;

  lta_fault_filter u_filter (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .meas_valid_i(meas_valid_i),
    .meas_value_i(meas_value_i),
    .thr_low_i(thr_low),
    .thr_high_i(thr_high),
    .persist_i(persist),
    .hit_high_o(hit_high),
    .hit_low_o(hit_low),
    .conv_done_o(conv_done)
  );

  // Bus handshake: one wait cycle, then the transfer completes
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_take = bus_req & avs_waitrequest_o;
  assign wr_done = avs_write_i & ~avs_waitrequest_o;
  assign flags_rd = avs_read_i & bus_take & (avs_address_i == `LTA_OFS_FLAGS);

  assign cfg_word = {alert_dir, alert_func, persist, alert_polarity, latch_mode};

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      avs_waitrequest_o <= 1'b1;
    end
    else if (bus_req)
    begin
      avs_waitrequest_o <= ~avs_waitrequest_o;
    end
  end

  // Read mux
  always @*
  begin
    rd_word = 32'h00000000;
    case (avs_address_i)
      `LTA_OFS_THR_LOW:
      begin
        rd_word[`LTA_MEAS_W-1:0] = thr_low;
      end
      `LTA_OFS_THR_HIGH:
      begin
        rd_word[`LTA_MEAS_W-1:0] = thr_high;
      end
      `LTA_OFS_CONFIG:
      begin
        rd_word[6:0] = cfg_word;
      end
      `LTA_OFS_FLAGS:
      begin
        rd_word[`LTA_FLG_HIGH] = flag_high;
        rd_word[`LTA_FLG_LOW] = flag_low;
        rd_word[`LTA_FLG_PIN] = pin_sync;
      end
      default:
      begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      avs_readdata_o <= 32'h00000000;
    end
    else if (avs_read_i & bus_take)
    begin
      avs_readdata_o <= rd_word;
    end
  end

  // Writable registers
  always @*
  begin
    wr_word = 32'h00000000;
    case (avs_address_i)
      `LTA_OFS_THR_LOW:
      begin
        wr_word = lta_merge({4'h0, thr_low}, avs_writedata_i, avs_byteenable_i);
      end
      `LTA_OFS_THR_HIGH:
      begin
        wr_word = lta_merge({4'h0, thr_high}, avs_writedata_i, avs_byteenable_i);
      end
      `LTA_OFS_CONFIG:
      begin
        wr_word = lta_merge({25'h0000000, cfg_word}, avs_writedata_i, avs_byteenable_i);
      end
      default:
      begin
        wr_word = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      thr_low <= `LTA_RST_THR_LOW;
      thr_high <= `LTA_RST_THR_HIGH;
      {alert_dir, alert_func, persist, alert_polarity, latch_mode} <= `LTA_RST_CONFIG;
    end
    else if (wr_done)
    begin
      case (avs_address_i)
        `LTA_OFS_THR_LOW:
        begin
          thr_low <= wr_word[`LTA_MEAS_W-1:0];
        end
        `LTA_OFS_THR_HIGH:
        begin
          thr_high <= wr_word[`LTA_MEAS_W-1:0];
        end
        `LTA_OFS_CONFIG:
        begin
          latch_mode <= wr_word[`LTA_CFG_LATCH];
          alert_polarity <= wr_word[`LTA_CFG_POL];
          persist <= wr_word[`LTA_CFG_PERS_HI:`LTA_CFG_PERS_LO];
          alert_func <= wr_word[`LTA_CFG_FUNC_HI:`LTA_CFG_FUNC_LO];
          alert_dir <= wr_word[`LTA_CFG_DIR];
        end
        default:
        begin
          thr_low <= thr_low;
        end
      endcase
    end
  end

  // Flag and fault state update; a set in the clearing cycle wins
  always @*
  begin
    next_flag_high = flag_high;
    next_flag_low = flag_low;
    next_fault_state = fault_state;
    if (latch_mode)
    begin
      if (flags_rd)
      begin
        next_flag_high = 1'b0;
        next_flag_low = 1'b0;
        next_fault_state = 1'b0;
      end
      if (hit_high)
      begin
        next_flag_high = 1'b1;
        next_fault_state = 1'b1;
      end
      if (hit_low)
      begin
        next_flag_low = 1'b1;
        next_fault_state = 1'b1;
      end
    end
    else
    begin
      if (hit_high)
      begin
        next_flag_high = 1'b1;
        next_flag_low = 1'b0;
        next_fault_state = 1'b1;
      end
      else if (hit_low)
      begin
        next_flag_high = 1'b0;
        next_flag_low = 1'b1;
        next_fault_state = 1'b0;
      end
    end
  end

  // Flags update regardless of the pin function
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      flag_high <= 1'b0;
      flag_low <= 1'b0;
      fault_state <= 1'b0;
    end
    else
    begin
      flag_high <= next_flag_high;
      flag_low <= next_flag_low;
      fault_state <= next_fault_state;
    end
  end

  // Conversion-completion pulses
  always @*
  begin
    pulse_start = 1'b0;
    if (conv_done)
    begin
      case (alert_func)
        `LTA_FUNC_FAULT:
        begin
          pulse_start = 1'b0;
        end
        `LTA_FUNC_FIFO:
        begin
          pulse_start = (hist_cnt == `LTA_HIST_LAST);
        end
        default:
        begin
          pulse_start = 1'b1;
        end
      endcase
    end
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pulse_cnt <= 5'h00;
      hist_cnt <= 2'h0;
    end
    else
    begin
      if (conv_done)
      begin
        hist_cnt <= hist_cnt + 2'h1;
      end
      if (pulse_start)
      begin
        pulse_cnt <= PULSE_CYC[4:0];
      end
      else if (pulse_cnt != 5'h00)
      begin
        pulse_cnt <= pulse_cnt - 5'h01;
      end
    end
  end

  // Alert pin drive
  always @*
  begin
    pin_active = (alert_func == `LTA_FUNC_FAULT) ? fault_state : (pulse_cnt != 5'h00);
    next_pull = alert_dir & lta_pull_low(pin_active, alert_polarity);
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      alert_pin_o <= 1'b0;
      alert_pin_oe_o <= 1'b0;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      alert_pin_o <= 1'b0;
      alert_pin_oe_o <= next_pull;
      pin_meta <= alert_pin_i;
      pin_sync <= pin_meta;
    end
  end

endmodule // lta_top

// ### lta_top_sva.sv
// Checker for the alert logic ports; tracks config and limits from bus writes.
// Assumes full byte lanes on every register write and spaced measurements.
`timescale 1ns/10ps
`include "lta_consts.vh"
module lta_top_chk (
  input wire core_clk_i,
  input wire rst_i,
  input wire [`LTA_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire avs_waitrequest_o,
  input wire meas_valid_i,
  input wire [`LTA_MEAS_W-1:0] meas_value_i,
  input wire alert_pin_o,
  input wire alert_pin_oe_o
);
  reg [6:0] cfg;
  reg [27:0] lo;
  reg [27:0] hi;
  reg [3:0] run;
  reg [4:0] hrun;
  wire take = avs_write_i && !avs_waitrequest_o;
  wire flt = meas_value_i > hi || meas_value_i < lo;
  wire [4:0] run_n = flt ? {1'b0, run} + 5'h01 : 5'h00;
  wire [4:0] need = 5'h01 << cfg[3:2];
  wire fm = cfg[6] && cfg[5:4] == 2'h0;
  wire pol = cfg[1];
  wire rd_c = avs_read_i && avs_address_i == `LTA_OFS_FLAGS;
  wire up = meas_valid_i && fm && !cfg[0] && run_n >= need;
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cfg <= `LTA_RST_CONFIG;
      lo <= `LTA_RST_THR_LOW;
      hi <= `LTA_RST_THR_HIGH;
      run <= 4'h0;
      hrun <= 5'h00;
    end
    else
    begin
      if (take && avs_address_i == `LTA_OFS_CONFIG)
        cfg <= avs_writedata_i[6:0];
      if (take && avs_address_i == `LTA_OFS_THR_LOW)
        lo <= avs_writedata_i[27:0];
      if (take && avs_address_i == `LTA_OFS_THR_HIGH)
        hi <= avs_writedata_i[27:0];
      if (meas_valid_i)
        run <= run_n[4] ? 4'hF : run_n[3:0];
      hrun <= alert_pin_oe_o ? hrun + {4'h0, hrun != 5'h1F} : 5'h00;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_OD_LOW: assert property (alert_pin_o == 1'b0)
    else $error("alert pin output driven high");
  AST_BUS_WAIT: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one wait cycle");
  AST_NO_DRIVE: assert property (!cfg[6] && !$past(cfg[6]) |-> !alert_pin_oe_o)
    else $error("pin driven while set as input");
  AST_TR_UP: assert property (up && meas_value_i > hi |-> ##3 alert_pin_oe_o == !pol)
    else $error("pin not active above upper limit");
  AST_TR_DOWN: assert property (up && meas_value_i < lo |-> ##3 alert_pin_oe_o == pol)
    else $error("pin not inactive below lower limit");
  AST_PERSIST: assert property (meas_valid_i && fm && !cfg[0] && run_n < need
    && !$past(meas_valid_i) && !$past(meas_valid_i, 2) |-> ##3 $stable(alert_pin_oe_o))
    else $error("pin changed before fault run complete");
  AST_LATCH_HOLD: assert property (fm && cfg[0] && alert_pin_oe_o == !pol && !rd_c
    && !$past(rd_c) && !$past(rd_c, 2) |=> alert_pin_oe_o == !pol)
    else $error("latched alert released without flag read");
  AST_LATCH_CLR: assert property (rd_c && avs_waitrequest_o && fm && cfg[0]
    && !meas_valid_i && !$past(meas_valid_i) ##1 !meas_valid_i |-> ##2 alert_pin_oe_o == pol)
    else $error("latched alert not cleared by flag read");
  AST_PULSE_LEN: assert property (cfg[5:4] != 2'h0 && cfg[6] && !pol
    && $fell(alert_pin_oe_o) |-> hrun == `LTA_PULSE_CYC)
    else $error("completion pulse has wrong length");
endmodule // lta_top_chk

bind lta_top lta_top_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
  .meas_valid_i(meas_valid_i), .meas_value_i(meas_value_i), .alert_pin_o(alert_pin_o),
  .alert_pin_oe_o(alert_pin_oe_o));

// ### lta_line_model.sv
// Shared alert line with its pull-up, as the host side sees it.
// Assumes oe_i high means the device pulls the line.
`timescale 1ns/10ps
module lta_line_model (
  input wire oe_i,
  input wire o_i,
  output wire line_o
);
  assign line_o = oe_i ? o_i : 1'b1;
endmodule // lta_line_model

// ### lta_top_tb_top.sv
// Testbench for the alert logic: registers, limit flags, hold modes, pin pulses.
// Assumes the design, its checker and the line model are compiled first.
`timescale 1ns/10ps
`include "lta_consts.vh"
module lta_top_tb_top;
  localparam [27:0] HI_V = 28'h000012C;
  localparam [27:0] MID_V = 28'h00000C8;
  localparam [27:0] LO_V = 28'h0000032;
  reg core_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] adr = 8'h00;
  reg rd_q = 1'b0;
  reg wr_q = 1'b0;
  reg [31:0] wd = 32'h00000000;
  reg mv = 1'b0;
  reg [27:0] mval = 28'h0000000;
  reg apl = 1'b0;
  reg prv = 1'b0;
  reg [31:0] d;
  wire [31:0] rdata;
  wire wreq;
  wire pin_o;
  wire pin_oe;
  wire line;
  integer n_fail = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer rises = 0;
  integer p, c, r;
  always #50 core_clk_i = ~core_clk_i;
  lta_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .meas_valid_i(mv), .meas_value_i(mval),
    .alert_pin_i(line), .alert_pin_o(pin_o), .alert_pin_oe_o(pin_oe));
  lta_line_model u_line (.oe_i(pin_oe), .o_i(pin_o), .line_o(line));
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + (line === apl);
    rises <= rises + ((line === apl) && !prv);
    prv <= (line === apl);
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t value mismatch got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task bus(input w, input [7:0] a, input [31:0] v);
  begin
    @(posedge core_clk_i);
    adr <= a;
    wd <= v;
    wr_q <= w;
    rd_q <= !w;
    @(posedge core_clk_i);
    while (wreq !== 1'b0)
      @(posedge core_clk_i);
    d = rdata;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  end
  endtask
  task rc(input [7:0] a, input [31:0] e);
  begin
    repeat (3) @(posedge core_clk_i);
    bus(1'b0, a, 32'h00000000);
    chk(d, e);
  end
  endtask
  task m(input [27:0] v);
  begin
    @(posedge core_clk_i);
    mv <= 1'b1;
    mval <= v;
    @(posedge core_clk_i);
    mv <= 1'b0;
    repeat (5) @(posedge core_clk_i);
  end
  endtask
  function [31:0] cf(input l, input pl, input [1:0] ps, input [1:0] f);
    cf = {25'h0000000, 1'b1, f, ps, pl, l};
  endfunction
  task s_regs;
  begin
    rc(8'h04, 32'h0FFFFFFF);
    rc(8'h08, 32'h00000000);
    rc(8'h10, 32'h00000000);
    bus(1'b1, 8'h0C, 32'h00000007);
    rc(8'h0C, 32'h00000004);
    bus(1'b1, 8'h04, 32'hFFFFFFFF);
    rc(8'h04, 32'h0FFFFFFF);
    bus(1'b1, 8'h08, 32'hFFFFFFFF);
    rc(8'h08, 32'h0000007F);
    rc(8'h0C, 32'h00000000);
    bus(1'b1, 8'h00, 32'h00000064);
    bus(1'b1, 8'h04, 32'h000000C8);
  end
  endtask
  task s_trans;
  begin
    for (p = 0; p < 2; p = p + 1)
    begin
      bus(1'b1, 8'h08, cf(1'b0, p[0], 2'h0, 2'h0));
      m(HI_V);
      rc(8'h0C, {29'h00000000, p[0], 2'h1});
      m(MID_V);
      rc(8'h0C, {29'h00000000, p[0], 2'h1});
      m(LO_V);
      rc(8'h0C, {29'h00000000, ~p[0], 2'h2});
    end
  end
  endtask
  task s_persist;
  begin
    for (p = 0; p < 4; p = p + 1)
    begin
      bus(1'b1, 8'h08, cf(1'b0, 1'b0, p[1:0], 2'h0));
      m(MID_V);
      for (c = 1; c < (1 << p); c = c + 1)
        m(HI_V);
      m(MID_V);
      for (c = 1; c < (1 << p); c = c + 1)
        m(HI_V);
      rc(8'h0C, 32'h00000006);
      m(HI_V);
      rc(8'h0C, 32'h00000001);
      for (c = 0; c < (1 << p); c = c + 1)
        m(LO_V);
      rc(8'h0C, 32'h00000006);
    end
  end
  endtask
  task s_latch;
  begin
    bus(1'b1, 8'h08, cf(1'b1, 1'b0, 2'h0, 2'h0));
    bus(1'b0, 8'h0C, 32'h00000000);
    m(28'h0000064);
    rc(8'h0C, 32'h00000004);
    m(HI_V);
    m(MID_V);
    rc(8'h0C, 32'h00000001);
    rc(8'h0C, 32'h00000004);
    m(LO_V);
    m(HI_V);
    rc(8'h0C, 32'h00000003);
    rc(8'h0C, 32'h00000004);
  end
  endtask
  task s_pulse;
  begin
    bus(1'b1, 8'h08, cf(1'b0, 1'b0, 2'h0, 2'h1));
    c = cyc;
    m(HI_V);
    repeat (12) @(posedge core_clk_i);
    chk(cyc - c, 32'h0000000A);
    rc(8'h0C, 32'h00000005);
    bus(1'b1, 8'h08, cf(1'b0, 1'b0, 2'h0, 2'h3));
    r = rises;
    for (c = 0; c < 8; c = c + 1)
      m(MID_V);
    repeat (12) @(posedge core_clk_i);
    chk(rises - r, 32'h00000002);
    apl = 1'b1;
    bus(1'b1, 8'h08, cf(1'b0, 1'b1, 2'h0, 2'h1));
    repeat (3) @(posedge core_clk_i);
    c = cyc;
    m(LO_V);
    repeat (12) @(posedge core_clk_i);
    chk(cyc - c, 32'h0000000A);
  end
  endtask
  task test_done;
  begin
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    s_regs;
    s_trans;
    s_persist;
    s_latch;
    s_pulse;
    test_done;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_fail = n_fail + 1;
    test_done;
  end
endmodule // lta_top_tb_top
